/* gdc_current_cfg.sv */
`timescale 1ns/1ps
`include "gdc_map.svh"

// Function
// - bridge 1 register at index 0x0f, read/write, resets to 0xff
// - bridge 2 register at index 0x10, same layout, resets to 0xff
// - bits 7..4 hold source pull-up current code, reset all ones
// - bits 3..0 hold sink pull-down current code, reset all ones
// - bridge 2 upper nibble uses the same sixteen-level source table
// - normal codes 0..8 give 0.5 mA then 1..8 mA, rising
// - low-current selector switches codes to the microampere table

module gdc_current_cfg
    import gdc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // avalon-mm slave
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // gate drive current controls
    output gdc_drive_type o_bridge1_drive,
    output gdc_drive_type o_bridge2_drive
);

    gdc_state_type state_q;
    gdc_state_type state_d;

    logic [5:0] word_index;
    logic aligned;
    logic request;
    logic accept;
    logic write_en;
    logic [3:0] lut_code [4];
    logic lut_low [4];
    logic [15:0] lut_level [4];
    logic [15:0] level_read;
    logic [1:0] level_sel;

    // address split and bus handshake terms
    assign word_index = i_avs_address[7:2];
    assign aligned = (i_avs_address[1:0] == 2'h0);
    assign request = i_avs_read || i_avs_write;
    assign accept = request && !state_q.waitrequest;
    assign write_en = accept && i_avs_write && i_avs_byteenable[0];
    assign level_sel = 2'(word_index - `GDC_IDX_LEVEL_BASE);

    // decoder inputs: source and sink per bridge
    assign lut_code[0] = state_q.bridge1_drive_current[`GDC_SRC_MSB:`GDC_SRC_LSB];
    assign lut_code[1] = state_q.bridge1_drive_current[`GDC_SNK_MSB:`GDC_SNK_LSB];
    assign lut_code[2] = state_q.bridge2_drive_current[`GDC_SRC_MSB:`GDC_SRC_LSB];
    assign lut_code[3] = state_q.bridge2_drive_current[`GDC_SNK_MSB:`GDC_SNK_LSB];
    assign lut_low[0] = state_q.low_sel[`GDC_LOW_BR1_BIT];
    assign lut_low[1] = state_q.low_sel[`GDC_LOW_BR1_BIT];
    assign lut_low[2] = state_q.low_sel[`GDC_LOW_BR2_BIT];
    assign lut_low[3] = state_q.low_sel[`GDC_LOW_BR2_BIT];

    // one current decoder per code field
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lut
            gdc_current_lut u_lut (
                .i_clk(i_clk),
                .i_reset(i_reset),
                .i_code(lut_code[g]),
                .i_low_select(lut_low[g]),
                .o_level_ua(lut_level[g])
            );
        end
    endgenerate

    // pick the decoded level for a level read
    always_comb begin
        level_read = lut_level[level_sel];
    end

    // register bank and bus slave next state
    always_comb begin
        state_d = state_q;
        if (state_q.waitrequest) begin
            // one wait cycle: read data prepared before the accept edge
            if (request) begin
                state_d.waitrequest = 1'b0;
                state_d.rdata = `GDC_RST_RDATA;
                if (i_avs_read && aligned) begin
                    if (word_index == `GDC_IDX_BRIDGE1) begin
                        state_d.rdata = {24'h00_0000, state_q.bridge1_drive_current};
                    end else if (word_index == `GDC_IDX_BRIDGE2) begin
                        state_d.rdata = {24'h00_0000, state_q.bridge2_drive_current};
                    end else if (word_index == `GDC_IDX_LOW_SEL) begin
                        state_d.rdata = {30'h0, state_q.low_sel};
                    end else if (word_index >= `GDC_IDX_LEVEL_BASE
                                 && word_index <= `GDC_IDX_LEVEL_LAST) begin
                        state_d.rdata = {16'h0000, level_read};
                    end
                end
            end
        end else begin
            // accept edge: release the bus and commit a write
            state_d.waitrequest = 1'b1;
            if (write_en && aligned) begin
                if (word_index == `GDC_IDX_BRIDGE1) begin
                    // both nibbles land at once
                    state_d.bridge1_drive_current = i_avs_writedata[7:0];
                end else if (word_index == `GDC_IDX_BRIDGE2) begin
                    state_d.bridge2_drive_current = i_avs_writedata[7:0];
                end else if (word_index == `GDC_IDX_LOW_SEL) begin
                    state_d.low_sel = i_avs_writedata[1:0];
                end
            end
        end
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_q.waitrequest <= 1'b1;
            state_q.rdata <= `GDC_RST_RDATA;
            state_q.bridge1_drive_current <= `GDC_RST_BRIDGE;
            state_q.bridge2_drive_current <= `GDC_RST_BRIDGE;
            state_q.low_sel <= `GDC_RST_LOW_SEL;
        end else begin
            state_q <= state_d;
        end
    end

    // bus outputs straight from the state register
    assign o_avs_readdata = state_q.rdata;
    assign o_avs_waitrequest = state_q.waitrequest;

    // drive controls follow the stored fields directly
    assign o_bridge1_drive.source_current_code =
        state_q.bridge1_drive_current[`GDC_SRC_MSB:`GDC_SRC_LSB];
    assign o_bridge1_drive.sink_current_code =
        state_q.bridge1_drive_current[`GDC_SNK_MSB:`GDC_SNK_LSB];
    assign o_bridge1_drive.low_current_select = state_q.low_sel[`GDC_LOW_BR1_BIT];
    assign o_bridge2_drive.source_current_code =
        state_q.bridge2_drive_current[`GDC_SRC_MSB:`GDC_SRC_LSB];
    assign o_bridge2_drive.sink_current_code =
        state_q.bridge2_drive_current[`GDC_SNK_MSB:`GDC_SNK_LSB];
    assign o_bridge2_drive.low_current_select = state_q.low_sel[`GDC_LOW_BR2_BIT];

    // bus handshake checks
    a_wait_one_cycle: assert property (@(posedge i_clk) disable iff (i_reset)
        (request && o_avs_waitrequest) |=> !o_avs_waitrequest)
        else $error("waitrequest did not drop after one cycle");
    a_wait_release: assert property (@(posedge i_clk) disable iff (i_reset)
        !o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    // reset values seen right after release
    a_reset_all_ones: assert property (@(posedge i_clk) disable iff (i_reset)
        $past(i_reset) |-> (o_bridge1_drive.source_current_code == 4'hf
            && o_bridge1_drive.sink_current_code == 4'hf
            && o_bridge2_drive.source_current_code == 4'hf
            && o_bridge2_drive.sink_current_code == 4'hf))
        else $error("bridge registers not all ones after reset");

    // write reaches the drive controls at the accept edge
    a_bridge1_write: assert property (@(posedge i_clk) disable iff (i_reset)
        (write_en && aligned && word_index == 6'h0f)
            |=> (o_bridge1_drive.source_current_code == $past(i_avs_writedata[7:4])
                && o_bridge1_drive.sink_current_code == $past(i_avs_writedata[3:0])))
        else $error("bridge 1 write not on drive controls");
    a_bridge2_source: assert property (@(posedge i_clk) disable iff (i_reset)
        (write_en && aligned && word_index == 6'h10)
            |=> (o_bridge2_drive.source_current_code == $past(i_avs_writedata[7:4])))
        else $error("bridge 2 source code not stored");
    a_bridge2_sink: assert property (@(posedge i_clk) disable iff (i_reset)
        (write_en && aligned && word_index == 6'h10)
            |=> (o_bridge2_drive.sink_current_code == $past(i_avs_writedata[3:0])
                && $stable(o_bridge1_drive)))
        else $error("bridge 2 sink code not stored or bridge 1 disturbed");
    a_low_select_out: assert property (@(posedge i_clk) disable iff (i_reset)
        (write_en && aligned && word_index == 6'h20)
            |=> (o_bridge1_drive.low_current_select == $past(i_avs_writedata[0])
                && o_bridge2_drive.low_current_select == $past(i_avs_writedata[1])))
        else $error("low-current selector not on drive controls");

    // read returns the stored register at the accept edge
    a_bridge1_read: assert property (@(posedge i_clk) disable iff (i_reset)
        (accept && i_avs_read && aligned && word_index == 6'h0f)
            |-> (o_avs_readdata == {24'h00_0000, o_bridge1_drive.source_current_code,
                                    o_bridge1_drive.sink_current_code}))
        else $error("bridge 1 readback wrong");
    a_bridge2_read: assert property (@(posedge i_clk) disable iff (i_reset)
        (accept && i_avs_read && aligned && word_index == 6'h10)
            |-> (o_avs_readdata == {24'h00_0000, o_bridge2_drive.source_current_code,
                                    o_bridge2_drive.sink_current_code}))
        else $error("bridge 2 readback wrong");
    a_no_write_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        (!write_en) |=> ($stable(o_bridge1_drive) && $stable(o_bridge2_drive)))
        else $error("drive controls changed without a write");

    // writes touch only the register they address
    a_bridge1_only: assert property (@(posedge i_clk) disable iff (i_reset)
        (write_en && aligned && word_index == `GDC_IDX_BRIDGE1)
            |=> ($stable(o_bridge2_drive)
                && $stable(o_bridge1_drive.low_current_select)))
        else $error("bridge 1 write disturbed other controls");
    a_bridge2_keep_low: assert property (@(posedge i_clk) disable iff (i_reset)
        (write_en && aligned && word_index == `GDC_IDX_BRIDGE2)
            |=> $stable(o_bridge2_drive.low_current_select))
        else $error("bridge 2 write changed its low-current selector");
    a_low_keeps_codes: assert property (@(posedge i_clk) disable iff (i_reset)
        (write_en && aligned && word_index == `GDC_IDX_LOW_SEL)
            |=> ($stable(o_bridge1_drive[8:1]) && $stable(o_bridge2_drive[8:1])))
        else $error("selector write changed a current code");

    // refused writes and reads leave every control as it was
    a_lane_gated: assert property (@(posedge i_clk) disable iff (i_reset)
        (accept && i_avs_write && !i_avs_byteenable[0])
            |=> ($stable(o_bridge1_drive) && $stable(o_bridge2_drive)))
        else $error("write with lane 0 off changed a control");
    a_stray_write: assert property (@(posedge i_clk) disable iff (i_reset)
        (write_en && !aligned)
            |=> ($stable(o_bridge1_drive) && $stable(o_bridge2_drive)))
        else $error("misaligned write changed a control");
    a_unmapped_write: assert property (@(posedge i_clk) disable iff (i_reset)
        (write_en && aligned && word_index != `GDC_IDX_BRIDGE1
            && word_index != `GDC_IDX_BRIDGE2 && word_index != `GDC_IDX_LOW_SEL)
            |=> ($stable(o_bridge1_drive) && $stable(o_bridge2_drive)))
        else $error("unmapped write changed a control");
    a_read_keeps_regs: assert property (@(posedge i_clk) disable iff (i_reset)
        (accept && i_avs_read)
            |=> ($stable(o_bridge1_drive) && $stable(o_bridge2_drive)))
        else $error("read changed a control");

    // read data of the remaining places
    a_low_sel_read: assert property (@(posedge i_clk) disable iff (i_reset)
        (accept && i_avs_read && aligned && word_index == `GDC_IDX_LOW_SEL)
            |-> (o_avs_readdata == {30'h0, o_bridge2_drive.low_current_select,
                                    o_bridge1_drive.low_current_select}))
        else $error("low-current selector readback wrong");
    a_stray_read_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        (accept && i_avs_read && !aligned) |-> (o_avs_readdata == 32'h0000_0000))
        else $error("misaligned read not zero");
    a_unmapped_read: assert property (@(posedge i_clk) disable iff (i_reset)
        (accept && i_avs_read && aligned && word_index != `GDC_IDX_BRIDGE1
            && word_index != `GDC_IDX_BRIDGE2 && word_index != `GDC_IDX_LOW_SEL
            && (word_index < `GDC_IDX_LEVEL_BASE || word_index > `GDC_IDX_LEVEL_LAST))
            |-> (o_avs_readdata == 32'h0000_0000))
        else $error("unmapped read not zero");
    a_level_upper_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        (accept && i_avs_read && aligned && word_index >= `GDC_IDX_LEVEL_BASE
            && word_index <= `GDC_IDX_LEVEL_LAST)
            |-> (o_avs_readdata[31:16] == 16'h0000))
        else $error("level read upper half not zero");
    a_write_clears_rdata: assert property (@(posedge i_clk) disable iff (i_reset)
        (request && o_avs_waitrequest && i_avs_write) |=> (o_avs_readdata == 32'h0000_0000))
        else $error("write left stale read data");

    // handshake at rest and right after reset
    a_wait_idle_high: assert property (@(posedge i_clk) disable iff (i_reset)
        (!request && o_avs_waitrequest) |=> o_avs_waitrequest)
        else $error("waitrequest dropped with no request");
    a_readdata_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        !(request && o_avs_waitrequest) |=> $stable(o_avs_readdata))
        else $error("read data moved outside a prepare edge");
    a_reset_bus_idle: assert property (@(posedge i_clk) disable iff (i_reset)
        $past(i_reset) |-> (o_avs_waitrequest && o_avs_readdata == 32'h0000_0000
            && !o_bridge1_drive.low_current_select
            && !o_bridge2_drive.low_current_select))
        else $error("bus or selectors not idle after reset");

endmodule

/* gdc_map.svh */
`ifndef GDC_MAP_SVH
`define GDC_MAP_SVH

// register indices; byte address is four times the index
`define GDC_IDX_BRIDGE1 6'h0f
`define GDC_IDX_BRIDGE2 6'h10
`define GDC_IDX_LOW_SEL 6'h20
`define GDC_IDX_LEVEL_BASE 6'h22
`define GDC_IDX_LEVEL_LAST 6'h25

// reset values
`define GDC_RST_BRIDGE 8'hff
`define GDC_RST_LOW_SEL 2'h0
`define GDC_RST_LEVEL 16'h0000
`define GDC_RST_RDATA 32'h0000_0000

// field positions inside a bridge register
`define GDC_SRC_MSB 7
`define GDC_SRC_LSB 4
`define GDC_SNK_MSB 3
`define GDC_SNK_LSB 0

// field positions inside the low-current selector register
`define GDC_LOW_BR1_BIT 0
`define GDC_LOW_BR2_BIT 1

`endif

/* gdc_pkg.sv */
package gdc_pkg;

    // controls handed to one bridge's gate drive current sources
    typedef struct packed {
        logic [3:0] source_current_code;
        logic [3:0] sink_current_code;
        logic low_current_select;
    } gdc_drive_type;

    // state of the register bank
    typedef struct packed {
        logic waitrequest;
        logic [31:0] rdata;
        logic [7:0] bridge1_drive_current;
        logic [7:0] bridge2_drive_current;
        logic [1:0] low_sel;
    } gdc_state_type;

    // state of one current decoder
    typedef struct packed {
        logic [15:0] level_ua;
    } gdc_lut_state_type;

endpackage

/* gdc_current_lut.sv */
`timescale 1ns/1ps
`include "gdc_map.svh"

module gdc_current_lut
    import gdc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // code in
    input wire logic [3:0] i_code,
    input wire logic i_low_select,
    // decoded peak current in microamperes
    output logic [15:0] o_level_ua
);

    gdc_lut_state_type state_q;
    gdc_lut_state_type state_d;

    // code to current, normal or low-current table
    always_comb begin
        state_d = state_q;
        if (i_low_select) begin
            case (i_code)
                4'h0: state_d.level_ua = 16'h0032;
                4'h1: state_d.level_ua = 16'h006e;
                4'h2: state_d.level_ua = 16'h00aa;
                4'h3: state_d.level_ua = 16'h00e6;
                4'h4: state_d.level_ua = 16'h0122;
                4'h5: state_d.level_ua = 16'h015e;
                4'h6: state_d.level_ua = 16'h019a;
                4'h7: state_d.level_ua = 16'h0258;
                4'h8: state_d.level_ua = 16'h02d5;
                4'h9: state_d.level_ua = 16'h0352;
                4'ha: state_d.level_ua = 16'h03e8;
                4'hb: state_d.level_ua = 16'h04b0;
                4'hc: state_d.level_ua = 16'h0578;
                4'hd: state_d.level_ua = 16'h0640;
                4'he: state_d.level_ua = 16'h0708;
                default: state_d.level_ua = 16'h08fc;
            endcase
        end else begin
            case (i_code)
                4'h0: state_d.level_ua = 16'h01f4;
                4'h1: state_d.level_ua = 16'h03e8;
                4'h2: state_d.level_ua = 16'h07d0;
                4'h3: state_d.level_ua = 16'h0bb8;
                4'h4: state_d.level_ua = 16'h0fa0;
                4'h5: state_d.level_ua = 16'h1388;
                4'h6: state_d.level_ua = 16'h1770;
                4'h7: state_d.level_ua = 16'h1b58;
                4'h8: state_d.level_ua = 16'h1f40;
                4'h9: state_d.level_ua = 16'h2ee0;
                4'ha: state_d.level_ua = 16'h3e80;
                4'hb: state_d.level_ua = 16'h4e20;
                4'hc: state_d.level_ua = 16'h5dc0;
                4'hd: state_d.level_ua = 16'h7918;
                4'he: state_d.level_ua = 16'hbb80;
                default: state_d.level_ua = 16'hf230;
            endcase
        end
    end

    // level register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_q.level_ua <= `GDC_RST_LEVEL;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_level_ua = state_q.level_ua;

    // decoder checks
    a_normal_step_top: assert property (@(posedge i_clk) disable iff (i_reset)
        (!i_low_select && i_code == 4'h8) |=> (o_level_ua == 16'h1f40))
        else $error("normal code 8 not 8 mA");
    a_normal_max_code: assert property (@(posedge i_clk) disable iff (i_reset)
        (!i_low_select && i_code == 4'hf) |=> (o_level_ua == 16'hf230))
        else $error("normal code 15 not 62 mA");
    a_low_table_pick: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_low_select && i_code == 4'h1) |=> (o_level_ua == 16'h006e))
        else $error("low code 1 not 110 uA");
    a_normal_monotone: assert property (@(posedge i_clk) disable iff (i_reset)
        (!i_low_select && $past(!i_low_select) && i_code > $past(i_code))
            |=> (o_level_ua > $past(o_level_ua)))
        else $error("normal table not rising with code");

endmodule

/* gdc_current_cfg_tb.sv */
`timescale 1ns/1ps
`include "gdc_map.svh"

// compare one value and count it
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module testbench
    import gdc_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [7:0] i_avs_address = 8'h00;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0000_0000;
    logic [3:0] i_avs_byteenable = 4'hf;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    gdc_drive_type o_bridge1_drive;
    gdc_drive_type o_bridge2_drive;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    // code, normal level in ua, low-range level in ua
    logic [31:0] rows [16][3] = '{
        '{0, 500, 50}, '{1, 1000, 110}, '{2, 2000, 170}, '{3, 3000, 230},
        '{4, 4000, 290}, '{5, 5000, 350}, '{6, 6000, 410}, '{7, 7000, 600},
        '{8, 8000, 725}, '{9, 12000, 850}, '{10, 16000, 1000}, '{11, 20000, 1200},
        '{12, 24000, 1400}, '{13, 31000, 1600}, '{14, 48000, 1800}, '{15, 62000, 2300}};

    gdc_current_cfg u_gdc_current_cfg (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest),
        .o_bridge1_drive(o_bridge1_drive),
        .o_bridge2_drive(o_bridge2_drive)
    );

    // 50 mhz clock
    initial begin
        forever #10 i_clk = ~i_clk;
    end

    // hang guard
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            test_done();
        end
    end

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        i_avs_writedata <= d;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0);
        q = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        `CHK(n, 2)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        `CHK(q, e)
    endtask

    // verdict
    task automatic test_done();
        $display("errors %0d, checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        logic [3:0] c;
        logic [3:0] k;
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        // reset values of registers and controls
        #1;
        `CHK(o_bridge1_drive, 9'h1fe)
        `CHK(o_bridge2_drive, 9'h1fe)
        rd_chk(8'h3c, 32'h0000_00ff);
        rd_chk(8'h40, 32'h0000_00ff);
        rd_chk(8'h80, 32'h0000_0000);
        rd_chk(8'h88, 32'd62000);
        rd_chk(8'h94, 32'd62000);
        // every code in both ranges, different codes per field and bridge
        foreach (rows[i]) begin
            c = rows[i][0][3:0];
            k = 4'hf - c;
            wr(8'h3c, {24'h0, c, k});
            wr(8'h40, {24'h0, k, c});
            for (int s = 0; s < 2; s++) begin
                wr(8'h80, {30'h0, s[0] == 1'b0, s[0]});
                #1;
                `CHK(o_bridge1_drive, {c, k, s[0]})
                `CHK(o_bridge2_drive, {k, c, !s[0]})
                rd_chk(8'h80, {30'h0, s[0] == 1'b0, s[0]});
                rd_chk(8'h3c, {24'h0, c, k});
                rd_chk(8'h40, {24'h0, k, c});
                rd_chk(8'h88, rows[c][1 + s]);
                rd_chk(8'h8c, rows[k][1 + s]);
                rd_chk(8'h90, rows[k][2 - s]);
                rd_chk(8'h94, rows[c][2 - s]);
            end
        end
        // upper data bits dropped, upper read bits zero
        wr(8'h3c, 32'hffff_ff5a);
        rd_chk(8'h3c, 32'h0000_005a);
        // lane 0 disabled: write ignored
        i_avs_byteenable <= 4'he;
        wr(8'h3c, 32'h0000_0011);
        i_avs_byteenable <= 4'hf;
        rd_chk(8'h3c, 32'h0000_005a);
        // misaligned and unmapped places, read-only level register
        wr(8'h3d, 32'h0000_0022);
        wr(8'h44, 32'h0000_0033);
        wr(8'h88, 32'h0000_0044);
        rd_chk(8'h3c, 32'h0000_005a);
        rd_chk(8'h3d, 32'h0000_0000);
        rd_chk(8'h44, 32'h0000_0000);
        rd_chk(8'h40, 32'h0000_000f);
        // control follows a write straight away
        wr(8'h40, 32'h0000_0037);
        #1;
        `CHK(o_bridge2_drive[8:1], 8'h37)
        // reset in mid-run restores all ones
        @(posedge i_clk);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        #1;
        `CHK(o_bridge1_drive, 9'h1fe)
        `CHK(o_bridge2_drive, 9'h1fe)
        rd_chk(8'h40, 32'h0000_00ff);
        rd_chk(8'h3c, 32'h0000_00ff);
        test_done();
    end
endmodule
